// File: design/cxrc_defs.svh
// Constants for the context exchange and range check block
`ifndef CXRC_DEFS_SVH
`define CXRC_DEFS_SVH

// Parameter block shape
`define CX_BLK_LAST    4'hf
`define CX_IDX_P       4'h0
`define CX_IDX_IBASE   4'h1
`define CX_IDX_ILIM    4'h2
`define CX_IDX_DBASE   4'h3
`define CX_IDX_DLIM    4'h4
`define CX_IDX_FLAGS   4'h5
`define CX_IDX_MODE    4'h6
`define CX_IDX_MERR    4'h7
`define CX_IDX_AREG    4'h8
`define CX_IDX_SREG    4'hc

// Flag bits
`define CX_FLG_PRE     0
`define CX_FLG_ORE     1
`define CX_FLG_MEM     2

// Mode bits
`define CX_MOD_ICM     0
`define CX_MOD_IUM     1
`define CX_MOD_IOR     2

// Processor number field position
`define CX_PN_HI       31
`define CX_PN_LO       24

// Processor identifier, arbitrary value
`define CX_CPU_ID      8'h01

// Register port offsets
`define CX_REG_CTRL    3'h0
`define CX_REG_BLKADR  3'h1
`define CX_REG_STATUS  3'h2
`define CX_REG_CLEAR   3'h3
`define CX_REG_ENABLE  3'h4
`define CX_REG_PADDR   3'h5

// Status bits
`define CX_EV_DONE     0
`define CX_EV_PRE      1
`define CX_EV_ORE      2
`define CX_EV_MEM      3

`endif

// File: design/cxrc_pkg.sv
// Types for the context exchange and range check block
package cxrc_pkg;

    typedef logic [31:0] cxrc_word_t;
    typedef logic [23:0] cxrc_addr_t;

    typedef enum logic [2:0] {
        CX_IDLE  = 3'h0,
        CX_DRAIN = 3'h1,
        CX_RD    = 3'h2,
        CX_WAIT  = 3'h3,
        CX_WR    = 3'h4,
        CX_FETCH = 3'h5
    } cxrc_state_t;

endpackage

// File: design/cxrc_range.sv
// Relocation adder and limit compare
`timescale 1ns/1ps
`default_nettype none

module cxrc_range
    import cxrc_pkg::*;
(
    // Relocation inputs
    input  wire cxrc_addr_t base,
    input  wire cxrc_addr_t offset,
    input  wire cxrc_addr_t limit,
    // Result
    output cxrc_addr_t      abs_addr,
    output logic            over
);

    // Unsigned add and compare
    assign abs_addr = base + offset;
    assign over     = abs_addr > limit;

endmodule

`default_nettype wire

// File: design/cxrc_top.sv
// Context exchange sequencer with instruction and data range checks
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cxrc_defs.svh"

module cxrc_top
    import cxrc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Exchange causes
    input  wire logic       deadstart,
    input  wire logic       prog_exit,
    input  wire logic       issue_busy,
    output logic            issue_hold,
    // Instruction fetch stage
    input  wire logic       fetch_req,
    input  wire cxrc_addr_t fetch_p,
    output logic            fetch_go_r,
    output cxrc_addr_t      fetch_addr_r,
    // Data reference stage
    input  wire logic       dref_req,
    input  wire logic       dref_we,
    input  wire cxrc_addr_t dref_addr,
    output logic            dref_go_r,
    output logic            dref_we_r,
    output cxrc_addr_t      dref_abs_r,
    // Address and scalar register write port
    input  wire logic       areg_we,
    input  wire logic [2:0] areg_sel,
    input  wire cxrc_word_t areg_wdata,
    // Memory error report
    input  wire logic       merr_valid,
    input  wire logic       merr_correctable,
    input  wire logic [7:0] merr_syndrome,
    input  wire logic [4:0] merr_bank,
    input  wire logic [1:0] merr_port,
    input  wire logic [1:0] merr_chip,
    input  wire logic [1:0] merr_mode,
    // Central memory
    output logic            mem_req_r,
    output logic            mem_we_r,
    output cxrc_addr_t      mem_addr_r,
    output cxrc_word_t      mem_wdata_r,
    input  wire cxrc_word_t mem_rdata,
    // Register port
    input  wire logic [2:0] reg_addr,
    input  wire cxrc_word_t reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output cxrc_word_t      reg_rdata_r,
    // Interrupt
    output logic            irq
);

    cxrc_state_t st_r, st_nxt;
    logic [3:0]  idx_r, idx_nxt;
    cxrc_word_t  ctx_r [16];
    cxrc_word_t  ctx_nxt [16];
    logic        pend_r, pend_nxt;
    logic [7:0]  blk_r, blk_nxt;
    logic [3:0]  stat_r, stat_nxt;
    logic [3:0]  en_r, en_nxt;
    cxrc_word_t  rdata_nxt;
    logic        mreq_nxt, mwe_nxt, fgo_nxt, dgo_nxt, dwe_nxt;
    cxrc_addr_t  maddr_nxt, faddr_nxt, dabs_nxt;
    cxrc_word_t  mwdata_nxt;
    logic [3:0]  ev;
    logic        sw_xchg, cause, f_chk;
    logic [31:0] flags, mode;
    cxrc_addr_t  f_off, f_abs, d_abs;
    logic        f_over, d_over;

    // Block word address from its index
    function automatic cxrc_addr_t blk_word(input logic [7:0] b, input logic [3:0] i);
        blk_word = {12'h000, b, i};
    endfunction

    // Low 24 bits of a block word
    function automatic cxrc_addr_t lo24(input cxrc_word_t w);
        lo24 = w[23:0];
    endfunction

    assign flags = ctx_r[`CX_IDX_FLAGS];
    assign mode  = ctx_r[`CX_IDX_MODE];
    assign sw_xchg = reg_wr && reg_addr == `CX_REG_CTRL && reg_wdata[0];
    assign issue_hold = st_r != CX_IDLE;
    assign irq = |(stat_r & en_r);

    // Interrupt cause, operand range flag masked by its enable
    assign cause = flags[`CX_FLG_PRE] || flags[`CX_FLG_MEM]
                || (flags[`CX_FLG_ORE] && mode[`CX_MOD_IOR]);

    // Post exchange fetch uses loaded address
    assign f_chk = st_r == CX_FETCH || (fetch_req && st_r == CX_IDLE);
    assign f_off = st_r == CX_FETCH ? lo24(ctx_r[`CX_IDX_P]) : fetch_p;

    // Instruction relocation and check
    cxrc_range u_irange (
        .base     (lo24(ctx_r[`CX_IDX_IBASE])),
        .offset   (f_off),
        .limit    (lo24(ctx_r[`CX_IDX_ILIM])),
        .abs_addr (f_abs),
        .over     (f_over)
    );

    // Data relocation and check
    cxrc_range u_drange (
        .base     (lo24(ctx_r[`CX_IDX_DBASE])),
        .offset   (dref_addr),
        .limit    (lo24(ctx_r[`CX_IDX_DLIM])),
        .abs_addr (d_abs),
        .over     (d_over)
    );

    always_comb begin
        st_nxt     = st_r;
        idx_nxt    = idx_r;
        ctx_nxt    = ctx_r;
        pend_nxt   = pend_r;
        mreq_nxt   = 1'b0;
        mwe_nxt    = 1'b0;
        maddr_nxt  = mem_addr_r;
        mwdata_nxt = mem_wdata_r;
        fgo_nxt    = 1'b0;
        faddr_nxt  = fetch_addr_r;
        dgo_nxt    = 1'b0;
        dwe_nxt    = dref_we_r;
        dabs_nxt   = dref_abs_r;
        ev         = 4'h0;
        if (deadstart || prog_exit || sw_xchg) begin
            pend_nxt = 1'b1;
        end
        case (st_r)
            CX_IDLE: begin
                if (pend_r || cause) begin
                    st_nxt = CX_DRAIN;
                end
            end
            CX_DRAIN: begin
                if (!issue_busy) begin
                    st_nxt   = CX_RD;
                    idx_nxt  = 4'h0;
                    pend_nxt = deadstart || prog_exit || sw_xchg;
                end
            end
            CX_RD: begin
                mreq_nxt  = 1'b1;
                maddr_nxt = blk_word(blk_r, idx_r);
                st_nxt    = CX_WAIT;
            end
            CX_WAIT: begin
                st_nxt = CX_WR;
            end
            CX_WR: begin
                mreq_nxt   = 1'b1;
                mwe_nxt    = 1'b1;
                mwdata_nxt = ctx_r[idx_r];
                ctx_nxt[idx_r] = mem_rdata;
                if (idx_r == `CX_IDX_P) begin
                    mwdata_nxt[`CX_PN_HI:`CX_PN_LO] = `CX_CPU_ID;
                    ctx_nxt[idx_r][`CX_PN_HI:`CX_PN_LO] = 8'h00;
                end
                if (idx_r == `CX_BLK_LAST) begin
                    st_nxt = CX_FETCH;
                    ev[`CX_EV_DONE] = 1'b1;
                end else begin
                    st_nxt  = CX_RD;
                    idx_nxt = idx_r + 4'h1;
                end
            end
            CX_FETCH: begin
                st_nxt = CX_IDLE;
            end
            default: begin
                st_nxt = CX_IDLE;
            end
        endcase
        if (f_chk) begin
            if (f_over) begin
                ctx_nxt[`CX_IDX_FLAGS][`CX_FLG_PRE] = 1'b1;
                ev[`CX_EV_PRE] = 1'b1;
            end else begin
                fgo_nxt   = 1'b1;
                faddr_nxt = f_abs;
            end
        end
        if (dref_req && st_r == CX_IDLE) begin
            if (d_over) begin
                ctx_nxt[`CX_IDX_FLAGS][`CX_FLG_ORE] = 1'b1;
                ev[`CX_EV_ORE] = 1'b1;
            end else begin
                dgo_nxt  = 1'b1;
                dwe_nxt  = dref_we;
                dabs_nxt = d_abs;
            end
        end
        if (merr_valid && (merr_correctable ? mode[`CX_MOD_ICM] : mode[`CX_MOD_IUM])) begin
            ctx_nxt[`CX_IDX_MERR] = {12'h000, merr_mode, merr_chip, merr_port,
                                     merr_correctable, merr_bank, merr_syndrome};
            ctx_nxt[`CX_IDX_FLAGS][`CX_FLG_MEM] = 1'b1;
            ev[`CX_EV_MEM] = 1'b1;
        end
        // only A and S kept here
        if (areg_we && st_r == CX_IDLE) begin
            ctx_nxt[`CX_IDX_AREG + {1'b0, areg_sel}] = areg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r         <= CX_IDLE;
            idx_r        <= 4'h0;
            pend_r       <= 1'b0;
            mem_req_r    <= 1'b0;
            mem_we_r     <= 1'b0;
            mem_addr_r   <= 24'h000000;
            mem_wdata_r  <= 32'h00000000;
            fetch_go_r   <= 1'b0;
            fetch_addr_r <= 24'h000000;
            dref_go_r    <= 1'b0;
            dref_we_r    <= 1'b0;
            dref_abs_r   <= 24'h000000;
            for (int i = 0; i < 16; i++) begin
                ctx_r[i] <= 32'h00000000;
            end
        end else begin
            st_r         <= st_nxt;
            idx_r        <= idx_nxt;
            pend_r       <= pend_nxt;
            mem_req_r    <= mreq_nxt;
            mem_we_r     <= mwe_nxt;
            mem_addr_r   <= maddr_nxt;
            mem_wdata_r  <= mwdata_nxt;
            fetch_go_r   <= fgo_nxt;
            fetch_addr_r <= faddr_nxt;
            dref_go_r    <= dgo_nxt;
            dref_we_r    <= dwe_nxt;
            dref_abs_r   <= dabs_nxt;
            ctx_r        <= ctx_nxt;
        end
    end

    // Register port and sticky status
    always_comb begin
        blk_nxt   = blk_r;
        en_nxt    = en_r;
        stat_nxt  = stat_r;
        rdata_nxt = 32'h00000000;
        if (reg_wr && reg_addr == `CX_REG_BLKADR) begin
            blk_nxt = reg_wdata[7:0];
        end
        if (reg_wr && reg_addr == `CX_REG_ENABLE) begin
            en_nxt = reg_wdata[3:0];
        end
        if (reg_wr && reg_addr == `CX_REG_CLEAR) begin
            stat_nxt = stat_r & ~reg_wdata[3:0];
        end
        stat_nxt = stat_nxt | ev;
        if (reg_rd) begin
            case (reg_addr)
                `CX_REG_CTRL:   rdata_nxt = {28'h0000000, pend_r, st_r};
                `CX_REG_BLKADR: rdata_nxt = {24'h000000, blk_r};
                `CX_REG_STATUS: rdata_nxt = {28'h0000000, stat_r};
                `CX_REG_ENABLE: rdata_nxt = {28'h0000000, en_r};
                `CX_REG_PADDR:  rdata_nxt = {8'h00, lo24(ctx_r[`CX_IDX_P])};
                default:        rdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            blk_r       <= 8'h00;
            en_r        <= 4'h0;
            stat_r      <= 4'h0;
            reg_rdata_r <= 32'h00000000;
        end else begin
            blk_r       <= blk_nxt;
            en_r        <= en_nxt;
            stat_r      <= stat_nxt;
            reg_rdata_r <= rdata_nxt;
        end
    end

    drain_quiet_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_r == CX_DRAIN && issue_busy) |=> !mem_req_r && st_r == CX_DRAIN)
        else $error("exchange memory traffic before drain");

    // write follows read of same word
    read_first_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (mem_req_r && mem_we_r) |-> $past(mem_req_r, 2) && !$past(mem_we_r, 2)
            && $past(mem_addr_r, 2) == mem_addr_r)
        else $error("block word written without prior read");

    // fetch two cycles after last swap
    fetch_after_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_r == CX_WR && idx_r == `CX_BLK_LAST) |=> st_r == CX_FETCH
            ##1 (fetch_go_r || flags[`CX_FLG_PRE]))
        else $error("no fetch after exchange");

    cpu_id_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (mem_req_r && mem_we_r && mem_addr_r[3:0] == `CX_IDX_P)
            |-> mem_wdata_r[`CX_PN_HI:`CX_PN_LO] == `CX_CPU_ID)
        else $error("processor id missing from saved block");

    fetch_range_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (f_chk && f_over) |=> !fetch_go_r && flags[`CX_FLG_PRE] && stat_r[`CX_EV_PRE])
        else $error("fetch range error not flagged");

    dref_abort_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (dref_req && st_r == CX_IDLE && d_over) |=> !dref_go_r && flags[`CX_FLG_ORE])
        else $error("out of range data reference not aborted");

    dref_addr_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (dref_req && st_r == CX_IDLE && !d_over) |=> dref_go_r
            && dref_abs_r == $past(dref_addr) + $past(lo24(ctx_r[`CX_IDX_DBASE])))
        else $error("data address not relocated");

    // block traffic stays in aligned block
    blk_align_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        mem_req_r |-> mem_addr_r[23:12] == 12'h000 && mem_addr_r[11:4] == $past(blk_r, 2))
        else $error("block access outside aligned block");

endmodule

`default_nettype wire

// File: dv/cxrc_mem_model.sv
// Central memory model holding saved parameter blocks
`timescale 1ns/1ps
`default_nettype none

module cxrc_mem_model
    import cxrc_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Memory port
    input  wire logic       mem_req_r,
    input  wire logic       mem_we_r,
    input  wire cxrc_addr_t mem_addr_r,
    input  wire cxrc_word_t mem_wdata_r,
    output cxrc_word_t      mem_rdata,
    // Protocol slips seen
    output int              bad_cnt
);
    cxrc_word_t mem [0:4095];
    cxrc_word_t last_q;
    cxrc_addr_t rd_addr_q;
    logic       rd_q;

    initial begin
        bad_cnt = 0;
        rd_q = 1'b0;
        last_q = '0;
        rd_addr_q = '0;
    end

    // Read data only in the cycle after the request
    assign mem_rdata = rd_q ? last_q : ~last_q;

    always @(posedge clk) begin
        rd_q <= mem_req_r && !mem_we_r;
        if (mem_req_r && !mem_we_r) begin
            rd_addr_q <= mem_addr_r;
            last_q    <= mem[mem_addr_r[11:0]];
        end
        if (mem_req_r && mem_we_r) begin
            mem[mem_addr_r[11:0]] <= mem_wdata_r;
        end
        // Low 4096 words, write after read of same word
        bad_cnt <= bad_cnt + int'(mem_req_r && mem_addr_r[23:12] !== 12'h000)
                   + int'(mem_req_r && mem_we_r && mem_addr_r !== rd_addr_q);
    end
endmodule

`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the context exchange and range check block
`timescale 1ns/1ps
`default_nettype none
`include "cxrc_defs.svh"

module tb_top
    import cxrc_pkg::*;
;
    logic        clk, rst_n, deadstart, prog_exit, issue_busy, fetch_req, dref_req, dref_we;
    logic        areg_we, merr_valid, merr_correctable, mem_req_r, mem_we_r, reg_wr, reg_rd;
    logic        issue_hold, fetch_go_r, dref_go_r, dref_we_r, irq;
    logic [2:0]  areg_sel, reg_addr;
    logic [7:0]  merr_syndrome;
    logic [4:0]  merr_bank;
    logic [1:0]  merr_port, merr_chip, merr_mode;
    cxrc_addr_t  fetch_p, dref_addr, fetch_addr_r, dref_abs_r, mem_addr_r;
    cxrc_addr_t  p1, ib1, il1, db1, dl1, fa, off;
    cxrc_word_t  areg_wdata, mem_wdata_r, mem_rdata, reg_wdata, reg_rdata_r, rd, ew;
    cxrc_word_t  rv [0:7];
    logic [31:0] seed;
    logic [11:0] b;
    int          fails, n_tests, bad_cnt, i;

    cxrc_top DUT (.clk(clk), .rst_n(rst_n), .deadstart(deadstart), .prog_exit(prog_exit),
        .issue_busy(issue_busy), .issue_hold(issue_hold), .fetch_req(fetch_req),
        .fetch_p(fetch_p), .fetch_go_r(fetch_go_r), .fetch_addr_r(fetch_addr_r),
        .dref_req(dref_req), .dref_we(dref_we), .dref_addr(dref_addr), .dref_go_r(dref_go_r),
        .dref_we_r(dref_we_r), .dref_abs_r(dref_abs_r), .areg_we(areg_we),
        .areg_sel(areg_sel), .areg_wdata(areg_wdata), .merr_valid(merr_valid),
        .merr_correctable(merr_correctable), .merr_syndrome(merr_syndrome),
        .merr_bank(merr_bank), .merr_port(merr_port), .merr_chip(merr_chip),
        .merr_mode(merr_mode), .mem_req_r(mem_req_r), .mem_we_r(mem_we_r),
        .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r), .mem_rdata(mem_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r), .irq(irq));

    cxrc_mem_model MEM (.clk(clk), .mem_req_r(mem_req_r), .mem_we_r(mem_we_r),
        .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r), .mem_rdata(mem_rdata),
        .bad_cnt(bad_cnt));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rwr(input logic [2:0] a, input cxrc_word_t d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic rrd(input logic [2:0] a, output cxrc_word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata_r;
    endtask

    task automatic wait_fetch(output cxrc_addr_t a);
        int k;
        for (k = 0; k < 400 && fetch_go_r !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        a = fetch_addr_r;
        if (k == 400) begin
            chk("fetch_go_r", 1, 0);
            finish_test();
        end
    endtask

    task automatic xchg(input int c, output cxrc_addr_t a);
        @(posedge clk);
        issue_busy <= 1'b1;
        deadstart  <= (c == 1);
        prog_exit  <= (c == 2);
        merr_valid <= (c == 3);
        fetch_req  <= (c == 4);
        if (c == 0) rwr(`CX_REG_CTRL, 32'h1);
        @(posedge clk);
        {deadstart, prog_exit, merr_valid, fetch_req} <= '0;
        repeat (4) @(posedge clk);
        issue_busy <= 1'b0;
        wait_fetch(a);
    endtask

    task automatic load_blk();
        MEM.mem[b]     = {8'h00, p1};
        MEM.mem[b + 1] = {8'h00, ib1};
        MEM.mem[b + 2] = {8'h00, il1};
        MEM.mem[b + 3] = {8'h00, db1};
        MEM.mem[b + 4] = {8'h00, dl1};
        MEM.mem[b + 5] = 32'h0;
        MEM.mem[b + 6] = 32'h2;
    endtask

    always @(posedge clk) begin
        if (mem_req_r === 1'b1 && issue_busy) begin
            chk("mem_req_r", 0, 1);
        end
    end

    initial begin
        seed = 32'd55;
        fails = 0;
        n_tests = 0;
        {rst_n, deadstart, prog_exit, issue_busy, fetch_req, dref_req, dref_we} = '0;
        {areg_we, merr_valid, merr_correctable, reg_wr, reg_rd, areg_sel, reg_addr} = '0;
        {merr_syndrome, merr_bank, merr_port, merr_chip, merr_mode} = '0;
        {fetch_p, dref_addr, areg_wdata, reg_wdata} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i++) begin
            rrd(3'(i), rd);
            chk("reset reg", 0, rd);
        end
        $display("test reset done");
        b = {8'(rnd()), 4'h0};
        p1 = 24'(rnd()) & 24'h00ffff;
        ib1 = 24'(rnd()) & 24'h0fffff;
        il1 = ib1 + p1 + 24'h40;
        db1 = 24'(rnd()) & 24'h0fffff;
        dl1 = db1 + 24'h100;
        for (i = 0; i < 8; i++) begin
            rv[i] = rnd();
            MEM.mem[b + 8 + i] = rv[i];
            @(posedge clk);
            areg_we <= 1'b1;
            areg_sel <= 3'(i);
            areg_wdata <= ~rv[i];
        end
        @(posedge clk);
        areg_we <= 1'b0;
        load_blk();
        rwr(`CX_REG_BLKADR, {24'h0, b[11:4]});
        rrd(`CX_REG_BLKADR, rd);
        chk("blkadr", {24'h0, b[11:4]}, rd);
        xchg(0, fa);
        chk("fetch_addr_r", ib1 + p1, fa);
        chk("out word0", {`CX_CPU_ID, 24'h0}, MEM.mem[b]);
        for (i = 0; i < 8; i++) chk("out reg", ~rv[i], MEM.mem[b + 8 + i]);
        rrd(`CX_REG_PADDR, rd);
        chk("paddr", {8'h0, p1}, rd);
        $display("test exchange done");
        for (i = 0; i < 10; i++) begin
            off = (i == 0) ? 24'h100 : (i == 1) ? 24'h101 : 24'(rnd()) & 24'h1ff;
            @(posedge clk);
            dref_req <= 1'b1;
            dref_addr <= off;
            dref_we <= 1'(rnd());
            @(posedge clk);
            dref_req <= 1'b0;
            #1;
            chk("dref_go_r", off <= 24'h100, dref_go_r);
            if (off <= 24'h100) chk("dref_abs_r", db1 + off, dref_abs_r);
            if (off <= 24'h100) chk("dref_we_r", dref_we, dref_we_r);
        end
        chk("irq masked", 0, irq);
        rwr(`CX_REG_ENABLE, 32'h4);
        chk("irq", 1, irq);
        rwr(`CX_REG_CLEAR, 32'h4);
        chk("irq cleared", 0, irq);
        rrd(`CX_REG_STATUS, rd);
        chk("status", 32'h1, rd);
        @(posedge clk);
        fetch_req <= 1'b1;
        fetch_p <= p1 + 24'h40;
        @(posedge clk);
        fetch_req <= 1'b0;
        #1;
        chk("fetch_go_r", 1, fetch_go_r);
        chk("fetch_addr_r", ib1 + p1 + 24'h40, fetch_addr_r);
        $display("test range done");
        {merr_syndrome, merr_bank, merr_port, merr_chip, merr_mode} = 19'(rnd());
        merr_correctable = 1'b1;
        @(posedge clk);
        merr_valid <= 1'b1;
        @(posedge clk);
        merr_valid <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk("issue_hold", 0, issue_hold);
        rrd(`CX_REG_STATUS, rd);
        chk("status mem masked", 0, rd[`CX_EV_MEM]);
        {merr_syndrome, merr_bank, merr_port, merr_chip, merr_mode} = 19'(rnd());
        merr_correctable = 1'b0;
        ew = {12'h0, merr_mode, merr_chip, merr_port, 1'b0, merr_bank, merr_syndrome};
        xchg(3, fa);
        chk("fetch_addr_r", 0, fa);
        chk("merr word", ew, MEM.mem[b + 7]);
        chk("mem flag", 1, MEM.mem[b + 5][`CX_FLG_MEM]);
        chk("out ibase", {8'h0, ib1}, MEM.mem[b + 1]);
        chk("out dlimit", {8'h0, dl1}, MEM.mem[b + 4]);
        for (i = 0; i < 8; i++) chk("out reg", rv[i], MEM.mem[b + 8 + i]);
        $display("test memory error done");
        // Software clears flags before each return
        load_blk();
        fetch_p = 24'h5;
        xchg(4, fa);
        chk("fetch_addr_r", ib1 + p1, fa);
        chk("pre flag", 1, MEM.mem[b + 5][`CX_FLG_PRE]);
        chk("out id", `CX_CPU_ID, MEM.mem[b][31:24]);
        rrd(`CX_REG_STATUS, rd);
        chk("status pre", 1, rd[`CX_EV_PRE]);
        for (i = 1; i < 3; i++) begin
            load_blk();
            xchg(i, fa);
            chk("fetch_addr_r", ib1 + p1, fa);
        end
        chk("mem protocol", 0, bad_cnt);
        $display("test causes done");
        finish_test();
    end
endmodule

`default_nettype wire
